/* File: design/ufb_frame_baud.sv */
// Frame-format and baud-divisor configuration with its baud prescaler,
// parity generation and parity check.
// Assumes the shift paths sit outside, run on clk and use the strobes here.
`timescale 1ns/10ps

module ufb_frame_baud (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Byte-wide I/O port
    input  wire logic [0:0]       io_addr,
    input  wire logic             io_wr,
    input  wire logic             io_rd,
    input  wire logic [7:0]       io_wdata,
    output logic      [7:0]       io_rdata,
    // Bits held in the other control registers
    input  wire logic             double_speed_bit,
    input  wire logic             char_size_top_bit,
    // Configuration to the shift paths
    output ufb_pkg::ufb_cfg_s     cfg,
    // Baud timing
    output logic                  baud_tick,
    output logic                  bit_tick,
    output logic                  sync_clock_pin,
    output logic                  tx_change_strobe,
    output logic                  rx_sample_strobe,
    // Parity generation
    input  wire logic [8:0]       tx_data,
    output logic                  tx_parity_bit,
    // Parity check
    input  wire logic             rx_check,
    input  wire logic [8:0]       rx_data,
    input  wire logic             rx_parity_in,
    output logic                  parity_error_flag
);

    logic [6:0]  frame;
    logic [3:0]  baud_hi;
    logic [7:0]  baud_lo;
    logic [11:0] psc;
    logic [3:0]  phase;
    logic        prev_shared_rd;
    logic        wr_shared;
    logic        wr_low;
    logic        rd_shared;
    logic [8:0]  tx_mask;
    logic [8:0]  rx_mask;
    logic        rx_calc;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    assign wr_shared = io_wr && (io_addr == ufb_pkg::LOC_SHARED);
    assign wr_low    = io_wr && (io_addr == ufb_pkg::LOC_BAUD_LOW);
    assign rd_shared = io_rd && (io_addr == ufb_pkg::LOC_SHARED);

    always_ff @(posedge clk) begin
        if (rst) begin
            frame <= ufb_pkg::FRAME_RESET;
        end else if (wr_shared && io_wdata[ufb_pkg::REG_SEL_BIT]) begin
            frame <= io_wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            baud_hi <= ufb_pkg::DIVISOR_RESET[11:8];
        end else if (wr_shared && !io_wdata[ufb_pkg::REG_SEL_BIT]) begin
            baud_hi <= io_wdata[ufb_pkg::BAUD_HI_MSB:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            baud_lo <= ufb_pkg::DIVISOR_RESET[7:0];
        end else if (wr_low) begin
            baud_lo <= io_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // A lone read of the shared location yields the high byte; a read
    // in the cycle right after one yields frame control. Either read has
    // no side effect beyond arming that pairing.
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_shared_rd <= 1'b0;
        end else begin
            prev_shared_rd <= rd_shared;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else if (rd_shared && prev_shared_rd) begin
            io_rdata <= {1'b1, frame};
        end else if (rd_shared) begin
            io_rdata <= {4'h0, baud_hi};
        end else if (io_rd) begin
            io_rdata <= baud_lo;
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------------
    always_comb begin
        cfg = '0;
        cfg.sync_mode_select   = frame[ufb_pkg::SYNC_BIT];
        cfg.parity_mode_field  = frame[ufb_pkg::PARITY_HI:ufb_pkg::PARITY_LO];
        cfg.stop_bits_select   = frame[ufb_pkg::STOP_BIT];
        cfg.clock_polarity_bit = frame[ufb_pkg::POL_BIT];
        cfg.baud_divisor_value = {baud_hi, baud_lo};
        case ({char_size_top_bit, frame[ufb_pkg::SIZE_HI:ufb_pkg::SIZE_LO]})
            3'h0: cfg.char_bits = 4'h5;
            3'h1: cfg.char_bits = 4'h6;
            3'h2: cfg.char_bits = 4'h7;
            3'h3: cfg.char_bits = 4'h8;
            3'h7: cfg.char_bits = 4'h9;
            default: begin
                // Reserved codes fall back to eight bits and are flagged.
                cfg.char_bits          = ufb_pkg::SIZE_DEFAULT;
                cfg.char_size_reserved = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Baud prescaler
    // ------------------------------------------------------------------
    // reload on low write
    always_ff @(posedge clk) begin
        if (rst) begin
            psc <= ufb_pkg::DIVISOR_RESET;
        end else if (wr_low) begin
            psc <= {baud_hi, io_wdata};
        end else if (psc == 12'h000) begin
            psc <= {baud_hi, baud_lo};
        end else begin
            psc <= psc - 12'h001;
        end
    end

    assign baud_tick = !wr_low && (psc == 12'h000);

    always_ff @(posedge clk) begin
        if (rst || wr_low) begin
            phase <= 4'h0;
        end else if (baud_tick) begin
            if (double_speed_bit && phase >= ufb_pkg::OVERSAMPLE_DOUBLE) begin
                phase <= 4'h0;
            end else begin
                phase <= phase + 4'h1;
            end
        end
    end

    assign bit_tick = baud_tick && !cfg.sync_mode_select
                      && (phase == (double_speed_bit
                          ? ufb_pkg::OVERSAMPLE_DOUBLE
                          : ufb_pkg::OVERSAMPLE_NORMAL));

    // ------------------------------------------------------------------
    // Synchronous clock and edge strobes
    // ------------------------------------------------------------------
    // The clock toggles on each prescaler tick, so one bit lasts two
    // ticks; the double-speed bit does not reach this path.
    always_ff @(posedge clk) begin
        if (rst || !cfg.sync_mode_select) begin
            sync_clock_pin <= 1'b0;
        end else if (baud_tick) begin
            sync_clock_pin <= !sync_clock_pin;
        end
    end

    assign tx_change_strobe = cfg.sync_mode_select && baud_tick
                              && (sync_clock_pin == cfg.clock_polarity_bit);
    assign rx_sample_strobe = cfg.sync_mode_select && baud_tick
                              && (sync_clock_pin != cfg.clock_polarity_bit);

    // ------------------------------------------------------------------
    // Parity
    // ------------------------------------------------------------------
    assign tx_mask = 9'h1ff >> (4'h9 - cfg.char_bits);
    assign rx_mask = tx_mask;
    assign rx_calc = ^(rx_data & rx_mask)
                     ^ (cfg.parity_mode_field == ufb_pkg::PAR_ODD);

    always_ff @(posedge clk) begin
        if (rst || !cfg.parity_mode_field[1]) begin
            tx_parity_bit <= 1'b0;
        end else begin
            tx_parity_bit <= ^(tx_data & tx_mask)
                ^ (cfg.parity_mode_field == ufb_pkg::PAR_ODD);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            parity_error_flag <= 1'b0;
        end else begin
            parity_error_flag <= rx_check && cfg.parity_mode_field[1]
                                 && (rx_calc != rx_parity_in);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_wr_frame;
        @(posedge clk) disable iff (rst)
        (wr_shared && io_wdata[7]) |=> (frame == $past(io_wdata[6:0]));
    endproperty
    a_wr_frame: assert property (p_wr_frame)
        else $error("frame control write lost");

    property p_wr_high;
        @(posedge clk) disable iff (rst)
        (wr_shared && !io_wdata[7]) |=>
            (baud_hi == $past(io_wdata[3:0])) && $stable(frame);
    endproperty
    a_wr_high: assert property (p_wr_high)
        else $error("high byte write misrouted");

    property p_rd_frame;
        @(posedge clk) disable iff (rst)
        (rd_shared && prev_shared_rd) |=> (io_rdata == {1'b1, frame});
    endproperty
    a_rd_frame: assert property (p_rd_frame)
        else $error("frame control read wrong");

    property p_rd_high;
        @(posedge clk) disable iff (rst)
        (rd_shared && !prev_shared_rd) |=> (io_rdata[7:4] == 4'h0);
    endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("high byte read shows select set");

    property p_reload;
        @(posedge clk) disable iff (rst)
        wr_low |=> (psc == cfg.baud_divisor_value)
            && (baud_tick == (!wr_low && cfg.baud_divisor_value == 12'h000));
    endproperty
    a_reload: assert property (p_reload)
        else $error("prescaler not reloaded");

    property p_period;
        @(posedge clk) disable iff (rst)
        (baud_tick && cfg.baud_divisor_value == 12'h001 && !io_wr)
            ##1 !io_wr |-> !baud_tick ##1 (baud_tick || wr_low);
    endproperty
    a_period: assert property (p_period)
        else $error("prescaler period wrong");

    property p_sync_nobit;
        @(posedge clk) disable iff (rst)
        cfg.sync_mode_select |-> !bit_tick;
    endproperty
    a_sync_nobit: assert property (p_sync_nobit)
        else $error("bit tick in synchronous mode");

    property p_pol;
        @(posedge clk) disable iff (rst)
        (tx_change_strobe && !cfg.clock_polarity_bit) |=> sync_clock_pin;
    endproperty
    a_pol: assert property (p_pol)
        else $error("transmit edge wrong for polarity");

    property p_parity_err;
        @(posedge clk) disable iff (rst)
        (rx_check && cfg.parity_mode_field == ufb_pkg::PAR_EVEN
            && (^(rx_data & rx_mask) != rx_parity_in)) |=> parity_error_flag;
    endproperty
    a_parity_err: assert property (p_parity_err)
        else $error("parity mismatch not flagged");

    property p_parity_off;
        @(posedge clk) disable iff (rst)
        (cfg.parity_mode_field == ufb_pkg::PAR_OFF) |=>
            !tx_parity_bit && !parity_error_flag;
    endproperty
    a_parity_off: assert property (p_parity_off)
        else $error("parity active while disabled");

endmodule

/* File: design/ufb_pkg.sv */
// Shared constants and types of the frame-format and baud-divisor block.
// Assumes a byte-wide I/O port with one shared location and one low-byte
// location, all on the one system clock.
package ufb_pkg;

    // ------------------------------------------------------------------
    // I/O locations
    // ------------------------------------------------------------------
    localparam logic [0:0] LOC_SHARED   = 1'h0;
    localparam logic [0:0] LOC_BAUD_LOW = 1'h1;

    // ------------------------------------------------------------------
    // Field positions in the frame-control and divisor-high bytes
    // ------------------------------------------------------------------
    localparam int REG_SEL_BIT    = 7;
    localparam int SYNC_BIT       = 6;
    localparam int PARITY_HI      = 5;
    localparam int PARITY_LO      = 4;
    localparam int STOP_BIT       = 3;
    localparam int SIZE_HI        = 2;
    localparam int SIZE_LO        = 1;
    localparam int POL_BIT        = 0;
    localparam int BAUD_HI_MSB    = 3;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [6:0]  FRAME_RESET   = 7'h03 << 1;
    localparam logic [11:0] DIVISOR_RESET = 12'h000;
    localparam logic [1:0]  PAR_OFF       = 2'h0;
    localparam logic [1:0]  PAR_EVEN      = 2'h2;
    localparam logic [1:0]  PAR_ODD       = 2'h3;
    localparam logic [3:0]  OVERSAMPLE_NORMAL = 4'hf;
    localparam logic [3:0]  OVERSAMPLE_DOUBLE = 4'h7;
    localparam logic [3:0]  SIZE_DEFAULT  = 4'h8;

    // Decoded configuration handed to the shift paths.
    typedef struct packed {
        logic        sync_mode_select;
        logic [1:0]  parity_mode_field;
        logic        stop_bits_select;
        logic [3:0]  char_bits;
        logic        char_size_reserved;
        logic        clock_polarity_bit;
        logic [11:0] baud_divisor_value;
    } ufb_cfg_s;

endpackage

/* File: verification/ufb_peer.sv */
// Far serial node model: hands received characters to the parity checker.
// Assumes the bench names each character and whether its parity is spoiled.
`timescale 1ns/10ps

module ufb_peer (
    // Clock
    input  wire logic       clk,
    // Commands from the bench
    input  wire logic       send,
    input  wire logic       spoil,
    input  wire logic [8:0] data,
    input  wire logic       odd,
    // Character towards the checker
    output logic            rx_check = 1'b0,
    output logic [8:0]      rx_data = 9'h000,
    output logic            rx_parity_in = 1'b0
);
    // peer parity bit
    // Between characters the data lines invert on every cycle, so they show
    // the last character again on alternate cycles to a checker that samples late.
    always @(posedge clk) begin
        rx_check <= send;
        rx_data <= send ? data : ~rx_data;
        rx_parity_in <= (^data) ^ odd ^ spoil;
    end
endmodule

/* File: verification/tb_ufb_frame_baud.sv */
// Self-checking bench of the frame-format and baud-divisor block.
// Assumes the design package and the peer model are compiled first.
`timescale 1ns/10ps

module tb_ufb_frame_baud;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              io_wr = 1'b0;
    logic              io_rd = 1'b0;
    logic [0:0]        io_addr = 1'h0;
    logic [7:0]        io_wdata = 8'h00;
    logic [7:0]        io_rdata;
    logic [7:0]        hi = 8'h00;
    logic              dsb = 1'b0;
    logic              cst = 1'b0;
    logic              send = 1'b0;
    logic              spoil = 1'b0;
    logic [8:0]        pdata = 9'h000;
    logic [8:0]        tx_data = 9'h000;
    logic [8:0]        rx_data;
    logic              rx_check;
    logic              rx_par;
    logic              baud_tick;
    logic              bit_tick;
    logic              sclk;
    logic              txs;
    logic              rxs;
    logic              tx_par;
    logic              perr;
    logic              rd_pend = 1'b0;
    logic [31:0]       seed = 32'h2a8e;
    logic [7:0]        expq[$];
    ufb_pkg::ufb_cfg_s cfg;
    int                bad_count = 0;
    int                comparisons = 0;

    ufb_frame_baud i_ufb_frame_baud (.clk(clk), .rst(rst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .double_speed_bit(dsb), .char_size_top_bit(cst), .cfg(cfg),
        .baud_tick(baud_tick), .bit_tick(bit_tick), .sync_clock_pin(sclk),
        .tx_change_strobe(txs), .rx_sample_strobe(rxs),
        .tx_data(tx_data), .tx_parity_bit(tx_par), .rx_check(rx_check),
        .rx_data(rx_data), .rx_parity_in(rx_par),
        .parity_error_flag(perr));
    ufb_peer i_ufb_peer (.clk(clk), .send(send), .spoil(spoil),
        .data(pdata), .odd(cfg.parity_mode_field[0]),
        .rx_check(rx_check), .rx_data(rx_data), .rx_parity_in(rx_par));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Read data is settled by the falling edge after the taking edge.
    always @(posedge clk) rd_pend <= io_rd;
    always @(negedge clk) begin
        if (rd_pend === 1'b1) begin
            chk(io_rdata, expq.pop_front());
        end
    end

    task final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        final_report;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction

    function automatic logic par(logic [8:0] d, int n, logic [1:0] p);
        logic [8:0] m;
        m = d & ((9'h1 << n) - 9'h1);
        return p[1] & ((^m) ^ p[0]);
    endfunction

    function automatic logic pick(int s);
        return s == 0 ? baud_tick : s == 1 ? bit_tick : s == 2 ? txs : rxs;
    endfunction

    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wr <= 1'b1;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask

    // Two back-to-back reads: divisor high first, then frame control.
    task automatic rd2(input logic [7:0] f);
        @(posedge clk);
        io_addr <= 1'h0;
        io_rd <= 1'b1;
        expq.push_back(hi);
        @(posedge clk);
        expq.push_back(f);
        @(posedge clk);
        io_rd <= 1'b0;
    endtask

    // Cycles to the next pulse of a strobe; skip waits for one first.
    task automatic per(input int s, input int exp, input bit skip);
        int n;
        n = 0;
        while (skip && pick(s) !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pick(s) !== 1'b1 && n < 3000);
        chk(n[15:0], exp[15:0]);
    endtask

    // Waits for the strobe, then looks at the pin one cycle later.
    task automatic edge_pin(input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk(sclk, v);
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        logic [6:0] f;
        logic [8:0] d;
        int         n;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd2(8'h86);
        chk(cfg.char_bits, 4'h8);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            f = seed[6:0];
            if (!f[6]) f[0] = 1'b0;
            wr(1'b0, {1'b1, f});
            @(negedge clk);
            chk(cfg.sync_mode_select, f[6]);
            chk(cfg.parity_mode_field, f[5:4]);
            chk(cfg.stop_bits_select, f[3]);
            chk(cfg.clock_polarity_bit, f[0]);
            hi = {4'h0, seed[11:8]};
            wr(1'b0, hi);
            @(negedge clk);
            chk(cfg.baud_divisor_value[11:8], seed[11:8]);
            rd2({1'b1, f});
        end
        $display("test shared location done");
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            cst <= c[2];
            wr(1'b0, {5'h10, c[1:0], 1'b0});
            @(negedge clk);
            n = c == 7 ? 9 : c > 3 ? 8 : c + 5;
            chk(cfg.char_bits, n[3:0]);
            chk(cfg.char_size_reserved, c inside {4, 5, 6});
        end
        $display("test character size done");
        for (int p = 0; p < 4; p++) begin
            for (int z = 0; z < 8; z += 7) begin
                @(posedge clk);
                cst <= z[2];
                wr(1'b0, {2'h2, p[1:0], 1'b0, z[1:0], 1'b0});
                n = z == 7 ? 9 : 5;
                for (int s = 0; s < 2; s++) begin
                    seed = lfsr(seed);
                    d = seed[8:0];
                    @(posedge clk);
                    tx_data <= d;
                    @(posedge clk);
                    @(negedge clk);
                    chk(tx_par, par(d, n, p[1:0]));
                    @(posedge clk);
                    send <= 1'b1;
                    spoil <= s[0];
                    pdata <= d & ((9'h1 << n) - 9'h1);
                    @(posedge clk);
                    send <= 1'b0;
                    @(posedge clk);
                    @(negedge clk);
                    chk(perr, p[1] & s[0]);
                end
            end
        end
        $display("test parity done");
        @(posedge clk);
        cst <= 1'b0;
        wr(1'b0, 8'h86);
        hi = 8'h00;
        wr(1'b0, hi);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            // Divisor one first, so the short-period check has work.
            n = (k == 0) ? 1 : seed[2:0];
            wr(1'b1, n[7:0]);
            per(0, n + 1, 1'b0);
            per(0, n + 1, 1'b1);
            @(posedge clk);
            dsb <= 1'b0;
            per(1, 16 * (n + 1), 1'b1);
            chk(sclk, 1'b0);
            @(posedge clk);
            dsb <= 1'b1;
            per(1, 8 * (n + 1), 1'b1);
        end
        $display("test async baud done");
        for (int pol = 0; pol < 2; pol++) begin
            wr(1'b0, {2'h3, 5'h06, pol[0]});
            per(2, 2 * (n + 1), 1'b1);
            edge_pin(2, ~pol[0]);
            edge_pin(3, pol[0]);
            n = 0;
            repeat (100) begin
                @(negedge clk);
                if (bit_tick !== 1'b0) n++;
            end
            chk(n[15:0], 16'h0000);
            n = seed[2:0];
        end
        $display("test sync clock done");
        final_report;
    end
endmodule
